// [trap_pkg.sv]
// Constants for the trap cause and NMI unit: cause codes, field positions.
// Assumes a 32-bit core with 100 MHz ref_clk and APB software access.
package trap_pkg;
   localparam logic [10:0] CAUSE_INSTR_ACCESS = 11'h001;
   localparam logic [10:0] CAUSE_ILLEGAL      = 11'h002;
   localparam logic [10:0] CAUSE_BREAKPOINT   = 11'h003;
   localparam logic [10:0] CAUSE_LOAD_FAULT   = 11'h005;
   localparam logic [10:0] CAUSE_STORE_FAULT  = 11'h007;
   localparam logic [10:0] CAUSE_ECALL        = 11'h00B;
   localparam logic [10:0] CAUSE_INSTR_BUS    = 11'h030;
   localparam logic [10:0] CAUSE_NMI_LOAD     = 11'h400;
   localparam logic [10:0] CAUSE_NMI_STORE    = 11'h401;
   localparam logic [4:0]  NMI_VEC_INDEX      = 5'h0F;
   localparam int          VEC_BASE_LSB       = 7;
   localparam int          MCAUSE_IRQ_BIT     = 31;
   localparam int          MSTATUS_MIE        = 3;
   localparam int          MSTATUS_PRIOR_IRQ_ENABLE       = 7;
   localparam int          DCSR_NMIP          = 3;
   localparam logic [31:0] MSTATUS_RESET      = 32'h0000_1800;
   localparam logic [31:0] DCSR_RESET         = 32'h4000_0013;
   localparam logic [31:0] MTVEC_RESET        = 32'h0000_0001;
   localparam logic [11:0] CSR_TIME           = 12'hC01;
   localparam logic [11:0] CSR_TIMEH          = 12'hC81;
   localparam int          MAX_OUTSTANDING    = 2;
   localparam int          NMI_RETIRE_LIMIT   = 2;
   // APB register byte addresses
   localparam logic [11:0] ADDR_MSTATUS = 12'h000;
   localparam logic [11:0] ADDR_MTVEC   = 12'h004;
   localparam logic [11:0] ADDR_MEPC    = 12'h008;
   localparam logic [11:0] ADDR_MCAUSE  = 12'h00C;
   localparam logic [11:0] ADDR_DCSR    = 12'h010;
   localparam logic [11:0] ADDR_CFG     = 12'h014;
   localparam int          CFG_ARCH_SEL = 0;
   localparam int          DCSR_STEP    = 2;
   localparam int          DCSR_STEP_IRQ_ENABLE  = 11;
endpackage

// [trap_cause_and_nmi_unit.sv]
// Exception cause selection, trap CSR update and imprecise bus-fault NMI.
// Assumes the pipeline presents the write-back instruction with its fault
// flags, and data bus responses return in order.
module trap_cause_and_nmi_unit #(
   parameter logic ADVANCED_IRQ_ARCH_SEL = 1'b0
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Write-back stage instruction
   input  wire logic        wbValid,
   input  wire logic [31:0] wbPc,
   input  wire logic        fetchBusErr,
   input  wire logic        memoryAttributeCheckFail,
   input  wire logic        execFromIo,
   input  wire logic        illegalEncoding,
   input  wire logic        customEncoding,
   input  wire logic        csrAccess,
   input  wire logic [11:0] csrAddr,
   input  wire logic        isEcall,
   input  wire logic        isEbreak,
   input  wire logic        storeIoMisaligned,
   input  wire logic        storeIoModified,
   input  wire logic        storeAtomicUnsupported,
   input  wire logic        loadIoMisaligned,
   input  wire logic        loadIoModified,
   input  wire logic        loadReservedUnsupported,
   // Debug state
   input  wire logic        debugMode,
   // Data bus
   input  wire logic        dataReq,
   input  wire logic        dataGnt,
   input  wire logic        dataWe,
   input  wire logic        dataRvalid,
   input  wire logic        dataErr,
   // Trap outputs
   output logic             trapTaken,
   output logic             nmiTaken,
   output logic [31:0]      trapTarget,
   output logic             retireAllow,
   output logic             killLater,
   output logic             nmiPending,
   output logic             advancedIrqArchSel,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   logic [31:0] mstatus_r, mtvec_r, mepc_r, mcause_r, dcsr_r;
   logic        cfgArch_r;
   logic        nmiPend_r, nmiStore_r;
   localparam int MAX_OUTSTANDING_W = trap_pkg::MAX_OUTSTANDING;
   logic [1:0]  retireCnt_r;
   logic [MAX_OUTSTANDING_W-1:0] outWe_r;
   logic [1:0]  outCnt_r;

   // Exception detection is never gated by any enable
   wire timeAccess = csrAccess &&
      (csrAddr == trap_pkg::CSR_TIME || csrAddr == trap_pkg::CSR_TIMEH);
   wire excAccess  = execFromIo || memoryAttributeCheckFail;
   wire excBus     = fetchBusErr;
   wire excIllegal = (illegalEncoding && !customEncoding)
                     || timeAccess;
   wire excStore   = storeIoMisaligned || storeIoModified
                     || storeAtomicUnsupported;
   wire excLoad    = loadIoMisaligned || loadIoModified
                     || loadReservedUnsupported;
   wire excAny = wbValid && (excAccess || excBus || excIllegal || isEcall
                 || isEbreak || excStore || excLoad);

   // Priority encode; only the top cause is reported
   wire [10:0] excCause =
      excAccess  ? trap_pkg::CAUSE_INSTR_ACCESS :
      excBus     ? trap_pkg::CAUSE_INSTR_BUS    :
      excIllegal ? trap_pkg::CAUSE_ILLEGAL      :
      isEcall    ? trap_pkg::CAUSE_ECALL        :
      isEbreak   ? trap_pkg::CAUSE_BREAKPOINT   :
      excStore   ? trap_pkg::CAUSE_STORE_FAULT  :
                   trap_pkg::CAUSE_LOAD_FAULT;

   // NMI masking: ignores MIE, held off by debug or quiet stepping
   wire stepQuiet = dcsr_r[trap_pkg::DCSR_STEP] &&
                    !dcsr_r[trap_pkg::DCSR_STEP_IRQ_ENABLE];
   wire nmiVisible = nmiPend_r && !debugMode && !stepQuiet;
   // Retirement blocked once the retire budget is spent; NMI taken in the first visible cycle with no exception
   wire nmiForce = nmiVisible &&
      retireCnt_r == 2'(trap_pkg::NMI_RETIRE_LIMIT);
   wire takeNmi = nmiVisible && !excAny;
   wire takeExc = excAny;

   assign trapTaken   = takeExc || takeNmi;
   assign nmiTaken    = takeNmi;
   assign retireAllow = wbValid && !trapTaken && !nmiForce;
   assign killLater   = trapTaken;
   assign nmiPending  = nmiPend_r;
   assign advancedIrqArchSel = ADVANCED_IRQ_ARCH_SEL | cfgArch_r;
   assign trapTarget  = takeNmi ?
      {mtvec_r[31:trap_pkg::VEC_BASE_LSB], trap_pkg::NMI_VEC_INDEX, 2'b00}
      : {mtvec_r[31:2], 2'b00};

   // Outstanding transaction direction shift register, in order
   wire issue = dataReq && dataGnt;
   wire respWe = outWe_r[0];
   wire busFault = dataRvalid && dataErr;
   wire faultStore = respWe;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         outWe_r  <= '0;
         outCnt_r <= 2'b00;
      end else begin
         case ({issue, dataRvalid})
            2'b10: begin
               outWe_r[outCnt_r[0]] <= dataWe;
               outCnt_r <= outCnt_r + 2'b01;
            end
            2'b01: begin
               outWe_r  <= {1'b0, outWe_r[1]};
               outCnt_r <= outCnt_r - 2'b01;
            end
            2'b11: begin
               outWe_r  <= {1'b0, outWe_r[1]};
               outWe_r[outCnt_r[0] ^ 1'b1] <= dataWe;
            end
            default: ;
         endcase
      end
   end

   // Fault latch: first fault wins; reopened on handler entry
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         nmiPend_r  <= 1'b0;
         nmiStore_r <= 1'b0;
      end else if (takeNmi) begin
         // A fault in the entry cycle is kept: the set wins
         nmiPend_r  <= busFault;
         if (busFault) begin
            nmiStore_r <= faultStore;
         end
      end else if (busFault && !nmiPend_r) begin
         nmiPend_r  <= 1'b1;
         nmiStore_r <= faultStore;
      end
   end

   // Retirements since NMI became visible; buffered stores just arrive late
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         retireCnt_r <= 2'b00;
      end else if (!nmiVisible) begin
         retireCnt_r <= 2'b00;
      end else if (retireAllow) begin
         retireCnt_r <= retireCnt_r + 2'b01;
      end
   end

   // APB
   wire apbWr = psel && penable && pwrite;
   wire [31:0] dcsrView = dcsr_r | ({31'h0000_0000, nmiPend_r}
                          << trap_pkg::DCSR_NMIP);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !(paddr == trap_pkg::ADDR_MSTATUS
      || paddr == trap_pkg::ADDR_MTVEC || paddr == trap_pkg::ADDR_MEPC
      || paddr == trap_pkg::ADDR_MCAUSE || paddr == trap_pkg::ADDR_CFG
      || (paddr == trap_pkg::ADDR_DCSR && debugMode));
   always_comb begin
      case (paddr)
         trap_pkg::ADDR_MSTATUS: prdata = mstatus_r;
         trap_pkg::ADDR_MTVEC:   prdata = mtvec_r;
         trap_pkg::ADDR_MEPC:    prdata = mepc_r;
         trap_pkg::ADDR_MCAUSE:  prdata = mcause_r;
         trap_pkg::ADDR_DCSR:    prdata = debugMode ? dcsrView : '0;
         trap_pkg::ADDR_CFG:     prdata = {31'h0000_0000, cfgArch_r};
         default:                prdata = '0;
      endcase
   end

   wire [31:0] nmiCause = {1'b1, 20'h0_0000, nmiStore_r ?
      trap_pkg::CAUSE_NMI_STORE : trap_pkg::CAUSE_NMI_LOAD};
   wire [31:0] entryStatus = (mstatus_r
      & ~(32'h0000_0001 << trap_pkg::MSTATUS_PRIOR_IRQ_ENABLE)
      & ~(32'h0000_0001 << trap_pkg::MSTATUS_MIE))
      | ({31'h0000_0000, mstatus_r[trap_pkg::MSTATUS_MIE]}
         << trap_pkg::MSTATUS_PRIOR_IRQ_ENABLE);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mstatus_r <= trap_pkg::MSTATUS_RESET;
         mtvec_r   <= trap_pkg::MTVEC_RESET;
         mepc_r    <= '0;
         mcause_r  <= '0;
         dcsr_r    <= trap_pkg::DCSR_RESET;
         cfgArch_r <= 1'b0;
      end else if (trapTaken) begin
         mstatus_r <= entryStatus;
         mepc_r    <= wbPc;
         mcause_r  <= takeNmi ? nmiCause : {21'h00_0000, excCause};
      end else if (apbWr) begin
         case (paddr)
            trap_pkg::ADDR_MSTATUS: mstatus_r <= pwdata;
            trap_pkg::ADDR_MTVEC:   mtvec_r   <= pwdata;
            trap_pkg::ADDR_MEPC:    mepc_r    <= pwdata;
            trap_pkg::ADDR_MCAUSE:  mcause_r  <= pwdata;
            trap_pkg::ADDR_DCSR:    if (debugMode) dcsr_r <= pwdata;
            trap_pkg::ADDR_CFG:     cfgArch_r <= pwdata[trap_pkg::CFG_ARCH_SEL];
            default: ;
         endcase
      end
   end

   // Steps shared by the checks below
   sequence s_no_upper;
      !excAccess && !excBus && !excIllegal && !isEcall && !isEbreak;
   endsequence

   sequence s_nmi_ready;
      nmiPend_r && !debugMode && !stepQuiet && !excAny;
   endsequence

   sequence s_fault_open;
      busFault && !nmiPend_r;
   endsequence

   sequence s_fault_held;
      nmiPend_r && nmiStore_r == $past(faultStore);
   endsequence

   property p_exc_prio;
      @(posedge ref_clk) disable iff (rst)
      (wbValid && excAccess) |=> mcause_r == 32'h0000_0001;
   endproperty
   a_exc_prio: assert property (p_exc_prio)
      else $error("prio");

   property p_bus48;
      @(posedge ref_clk) disable iff (rst)
      (wbValid && fetchBusErr && !excAccess) |=> mcause_r == 32'h0000_0030;
   endproperty
   a_bus48: assert property (p_bus48)
      else $error("cause 48");

   property p_nmi_mie;
      @(posedge ref_clk) disable iff (rst)
      takeNmi |=> !mstatus_r[trap_pkg::MSTATUS_MIE];
   endproperty
   a_nmi_mie: assert property (p_nmi_mie)
      else $error("mie");

   property p_nmi_vec;
      @(posedge ref_clk) disable iff (rst)
      takeNmi |-> trapTarget[6:0] == 7'h3C;
   endproperty
   a_nmi_vec: assert property (p_nmi_vec)
      else $error("vector");

   property p_debug_hold;
      @(posedge ref_clk) disable iff (rst)
      debugMode |-> !takeNmi;
   endproperty
   a_debug_hold: assert property (p_debug_hold)
      else $error("debug");

   property p_first_kept;
      @(posedge ref_clk) disable iff (rst)
      (nmiPend_r && !takeNmi) |=> $stable(nmiStore_r) && nmiPend_r;
   endproperty
   a_first_kept: assert property (p_first_kept)
      else $error("latch");

   property p_reopen;
      @(posedge ref_clk) disable iff (rst)
      takeNmi |=> nmiPend_r == $past(busFault);
   endproperty
   a_reopen: assert property (p_reopen)
      else $error("reopen");

   property p_retire_bound;
      @(posedge ref_clk) disable iff (rst)
      nmiVisible |-> retireCnt_r <= 2'd2;
   endproperty
   a_retire_bound: assert property (p_retire_bound)
      else $error("bound");

   property p_time_illegal;
      @(posedge ref_clk) disable iff (rst)
      (wbValid && timeAccess && !excAccess && !excBus)
      |=> mcause_r == 32'h0000_0002;
   endproperty
   a_time_illegal: assert property (p_time_illegal)
      else $error("time");

   property p_store_cause;
      @(posedge ref_clk) disable iff (rst)
      (wbValid && excStore) ##0 s_no_upper
      |=> mcause_r == 32'(trap_pkg::CAUSE_STORE_FAULT);
   endproperty
   a_store_cause: assert property (p_store_cause)
      else $error("store cause");

   property p_load_cause;
      @(posedge ref_clk) disable iff (rst)
      (wbValid && excLoad && !excStore) ##0 s_no_upper
      |=> mcause_r == 32'(trap_pkg::CAUSE_LOAD_FAULT);
   endproperty
   a_load_cause: assert property (p_load_cause)
      else $error("load cause");

   property p_nmi_cause;
      @(posedge ref_clk) disable iff (rst)
      takeNmi |=> mcause_r == {1'b1, 20'h0_0000, $past(nmiStore_r) ?
         trap_pkg::CAUSE_NMI_STORE : trap_pkg::CAUSE_NMI_LOAD};
   endproperty
   a_nmi_cause: assert property (p_nmi_cause)
      else $error("nmi cause");

   property p_entry_status;
      @(posedge ref_clk) disable iff (rst)
      trapTaken |=> mstatus_r[trap_pkg::MSTATUS_PRIOR_IRQ_ENABLE]
         == $past(mstatus_r[trap_pkg::MSTATUS_MIE]);
   endproperty
   a_entry_status: assert property (p_entry_status)
      else $error("prior enable");

   property p_entry_pc;
      @(posedge ref_clk) disable iff (rst)
      trapTaken |=> mepc_r == $past(wbPc);
   endproperty
   a_entry_pc: assert property (p_entry_pc)
      else $error("return pc");

   property p_kill;
      @(posedge ref_clk) disable iff (rst)
      trapTaken |-> killLater && !retireAllow;
   endproperty
   a_kill: assert property (p_kill)
      else $error("kill");

   property p_debug_exit;
      @(posedge ref_clk) disable iff (rst)
      s_nmi_ready |-> takeNmi;
   endproperty
   a_debug_exit: assert property (p_debug_exit)
      else $error("nmi not taken");

   // Imprecise: the fault only arms the latch, no trap is forced here
   property p_fault_latch;
      @(posedge ref_clk) disable iff (rst)
      s_fault_open |=> s_fault_held;
   endproperty
   a_fault_latch: assert property (p_fault_latch)
      else $error("fault latch");
endmodule

// [data_bus_model.sv]
// Data bus fabric model: one load or store per go pulse, granted at once.
// Assumes go is a single-cycle pulse and lat is at least one.
module data_bus_model (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic       we,
   input  wire logic       err,
   input  wire logic [3:0] lat,
   output logic            dataReq,
   output logic            dataGnt,
   output logic            dataWe,
   output logic            dataRvalid,
   output logic            dataErr
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] cnt_r;
   logic       err_r;
   assign dataGnt = dataReq;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {dataReq, dataWe, dataRvalid, dataErr, cnt_r, err_r} <= '0;
      end else begin
         dataReq <= go;
         // Released lines toggle so a stale value is never trusted
         dataWe <= go ? we : ~dataWe;
         dataRvalid <= cnt_r == 4'h1;
         dataErr <= cnt_r == 4'h1 ? err_r : ~dataErr;
         cnt_r <= go ? lat : cnt_r - 4'(cnt_r != 4'h0);
         if (go) err_r <= err;
      end
   end
endmodule

// [trap_cause_and_nmi_unit_bench.sv]
// Self-checking bench: trap causes, NMI latch and APB register view.
// Assumes the data bus model drives the bus fault responses.
module trap_cause_and_nmi_unit_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, rst, wbValid, customEncoding, csrAccess, debugMode;
   logic psel, penable, pwrite, go, we, err, pready, pslverr, advSel;
   logic spareE;
   logic [31:0] spareD;
   logic trapTaken, nmiTaken, retireAllow, killLater, nmiPending;
   logic dataReq, dataGnt, dataWe, dataRvalid, dataErr;
   logic [31:0] wbPc, pwdata, prdata, trapTarget;
   logic [11:0] exc, csrAddr, paddr;
   logic [3:0]  lat;
   int          fails, tests_run;
   logic [10:0] causeTab [12] = '{11'h001, 11'h001, 11'h030, 11'h002,
      11'h00B, 11'h003, 11'h007, 11'h007, 11'h007, 11'h005, 11'h005, 11'h005};
   trap_cause_and_nmi_unit dut_u (.ref_clk, .rst, .wbValid, .wbPc,
      .csrAccess, .csrAddr, .customEncoding, .debugMode, .dataReq, .dataGnt,
      .dataWe, .dataRvalid, .dataErr, .trapTaken, .nmiTaken, .trapTarget,
      .retireAllow, .killLater, .nmiPending, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr,
      .advancedIrqArchSel(advSel), .execFromIo(exc[0]),
      .memoryAttributeCheckFail(exc[1]), .fetchBusErr(exc[2]),
      .illegalEncoding(exc[3]), .isEcall(exc[4]), .isEbreak(exc[5]),
      .storeIoMisaligned(exc[6]), .storeIoModified(exc[7]),
      .storeAtomicUnsupported(exc[8]), .loadIoMisaligned(exc[9]),
      .loadIoModified(exc[10]), .loadReservedUnsupported(exc[11]));
   data_bus_model bus_u (.ref_clk, .rst, .go, .we, .err, .lat, .dataReq,
      .dataGnt, .dataWe, .dataRvalid, .dataErr);
   always #5 ref_clk = ~ref_clk;
   task stop_test;
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task check(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask
   task hang(input string nm);
      fails++;
      $display("unexpected %s: expected response, seen timeout", nm);
      stop_test();
   endtask
   // Starts one edge later so psel is never assigned twice in a step
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic e);
      int i;
      @(posedge ref_clk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge ref_clk) penable <= 1'h1;
      for (i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         if (pready === 1'h1) break;
      end
      if (i == 16) hang("pready");
      rd = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task rdChk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic        e;
      apb(1'h0, a, 32'h0000_0000, d, e);
      check($sformatf("reg %h", a), d, exp);
   endtask
   task test_regs;
      logic [31:0] d;
      logic        e;
      rdChk(trap_pkg::ADDR_MSTATUS, 32'h0000_1800);
      rdChk(trap_pkg::ADDR_MTVEC, 32'h0000_0001);
      apb(1'h0, trap_pkg::ADDR_DCSR, 32'h0000_0000, d, e);
      check("dcsr refused", 32'(e), 32'h0000_0001);
      apb(1'h0, 12'h018, 32'h0000_0000, d, e);
      check("unmapped", 32'(e), 32'h0000_0001);
      apb(1'h1, trap_pkg::ADDR_CFG, 32'h0000_0001, d, e);
      @(negedge ref_clk);
      check("arch sel", 32'(advSel), 32'h0000_0001);
      apb(1'h1, trap_pkg::ADDR_CFG, 32'h0000_0000, d, e);
      @(negedge ref_clk);
      check("arch sel", 32'(advSel), 32'h0000_0000);
      $display("register test done");
   endtask
   task excCase(input logic [11:0] f, input logic [10:0] cause,
                input logic trap, input logic v);
      @(posedge ref_clk);
      exc <= f; wbValid <= v; wbPc <= wbPc + 32'h0000_0004;
      @(negedge ref_clk);
      check("trapTaken", 32'(trapTaken), 32'(trap));
      check("killLater", 32'(killLater), 32'(trap));
      check("retire", 32'(retireAllow), 32'(!trap && v));
      // Exceptions go to the vector base; the reset base is zero
      if (trap) check("target", trapTarget, 32'h0000_0000);
      @(posedge ref_clk);
      exc <= '0; wbValid <= 1'h0; csrAccess <= 1'h0; customEncoding <= 1'h0;
      if (trap) begin
         rdChk(trap_pkg::ADDR_MCAUSE, 32'(cause));
         rdChk(trap_pkg::ADDR_MEPC, wbPc);
      end
   endtask
   task test_exc;
      for (int i = 0; i < 12; i++) begin
         excCase(12'hFFF << i, causeTab[i], 1'h1, 1'h1);
         excCase(12'h001 << i, causeTab[i], 1'h1, 1'h1);
      end
      excCase(12'h004, 11'h030, 1'h1, 1'h1);
      excCase(12'h002, 11'h000, 1'h0, 1'h0);
      @(posedge ref_clk) customEncoding <= 1'h1;
      excCase(12'h008, 11'h000, 1'h0, 1'h1);
      @(posedge ref_clk) customEncoding <= 1'h0;
      excCase(12'h008, 11'h002, 1'h1, 1'h1);
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         csrAccess <= 1'h1;
         csrAddr <= i ? 12'hC81 : 12'hC01;
         excCase(12'h000, 11'h002, 1'h1, 1'h1);
      end
      $display("exception test done");
   endtask
   task busOp(input logic w, input logic [3:0] l);
      int i;
      @(posedge ref_clk);
      go <= 1'h1; we <= w; err <= 1'h1; lat <= l;
      @(posedge ref_clk) go <= 1'h0;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (dataRvalid === 1'h1) break;
      end
      if (i == 20) hang("dataRvalid");
   endtask
   task nmiCase(input logic w, input logic [3:0] l);
      logic [31:0] d;
      logic        e;
      int          i;
      apb(1'h1, trap_pkg::ADDR_MSTATUS, 32'h0000_1808, d, e);
      @(posedge ref_clk) debugMode <= 1'h1;
      // Quiet single step must keep holding the NMI after debug exit
      apb(1'h1, trap_pkg::ADDR_DCSR, 32'h4000_0017, d, e);
      busOp(w, l);
      busOp(~w, 4'h1);
      @(negedge ref_clk);
      check("nmiPending", 32'(nmiPending), 32'h0000_0001);
      @(posedge ref_clk) wbValid <= 1'h1;
      repeat (4) begin
         @(negedge ref_clk);
         check("held off", 32'(nmiTaken), 32'h0000_0000);
      end
      @(posedge ref_clk) wbValid <= 1'h0;
      rdChk(trap_pkg::ADDR_DCSR, 32'h4000_001F);
      @(posedge ref_clk);
      debugMode <= 1'h0;
      wbValid <= 1'h1;
      repeat (4) begin
         @(negedge ref_clk);
         check("step hold", 32'(nmiTaken), 32'h0000_0000);
      end
      @(posedge ref_clk);
      debugMode <= 1'h1;
      wbValid <= 1'h0;
      apb(1'h1, trap_pkg::ADDR_DCSR, 32'h4000_0817, d, e);
      @(posedge ref_clk);
      debugMode <= 1'h0;
      wbValid <= 1'h1;
      for (i = 0; i < 3; i++) begin
         @(negedge ref_clk);
         if (nmiTaken === 1'h1) break;
      end
      if (i == 3) hang("nmiTaken");
      check("trapTarget", trapTarget, 32'h0000_103C);
      check("nmi retire", 32'(retireAllow), 32'h0000_0000);
      @(posedge ref_clk) wbValid <= 1'h0;
      rdChk(trap_pkg::ADDR_MCAUSE, 32'h8000_0400 | 32'(w));
      rdChk(trap_pkg::ADDR_MSTATUS, 32'h0000_1880);
      check("nmi cleared", 32'(nmiPending), 32'h0000_0000);
      $display("nmi test done");
   endtask
   initial begin
      ref_clk = 1'h0; rst = 1'h1; wbValid = 1'h0; wbPc = 32'h0000_2000;
      exc = '0; csrAccess = 1'h0; csrAddr = '0; customEncoding = 1'h0;
      debugMode = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
      paddr = '0; pwdata = '0; go = 1'h0; we = 1'h0; err = 1'h0; lat = 4'h1;
      fails = 0;
      tests_run = 0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'h0;
      test_regs();
      test_exc();
      rdChk(trap_pkg::ADDR_MTVEC, 32'h0000_0001);
      apb(1'h1, trap_pkg::ADDR_MTVEC, 32'h0000_1001, spareD, spareE);
      nmiCase(1'h0, 4'h1);
      nmiCase(1'h1, 4'h5);
      stop_test();
   end
endmodule
